// ==== logic/phy_addr_strap_led_pins.sv ====
// Shared PHY address strap and status LED pin logic
//
// Contract
// R01: Each shared pin is an input while power-on or hardware reset is in progress.
// R02: After reset each shared pin turns output and drives its status indication.
// R03: A low strap level gives address bit zero and a high level gives one.
// R04: Strap pins supply address bits 1 to 4 from collision, link, transmit and receive pins.
// R05: The latched address is used in hardware and software configured modes alike.
// R06: The bit 1 pin shows collision status after reset.
// R07: Each detected collision holds the collision indicator on for about 70 ms.
// R08: The bit 2 pin is asserted while a valid link exists.
// R09: The bit 3 pin is asserted while transmit activity is present.
// R10: The bit 4 pin is asserted while receive activity is present.
// R11: The board pulls every shared pin to a defined level and never leaves one floating.
// R12: Each strap level is captured as reset is left, before the pin turns output.
// R13: The asserted output level is the inverse of the level sampled during reset.
// R14: A software reset neither resamples the straps nor changes pin direction.
// R15: A fifth pin supplies address bit 0 and then shows transmit-or-receive activity.
// R16: The five latched bits form the PHY address, stable until the next hard reset.
//
// The straps pass the two-flop synchroniser while reset is held, so the
// captured value is the settled board level at the edge that leaves reset.
// Pins stay inputs for three edges after release: one to settle, one to sample, one to drive.
// The collision stretch is a count of core clock cycles, about 70 ms by default.
// Software reset is left unread here on purpose, so it cannot move the pins.
// The asserted level of each pin is the inverse of its strap level.
// Outputs all come from flops, so status shows one cycle after it changes.
`include "led_strap_consts.svh"
module phy_addr_strap_led_pins #(
  parameter logic [31:0] COL_STRETCH = 32'(`COL_STRETCH_CYCLES)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sw_reset,
  input wire logic collision,
  input wire logic link_up,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic [4:0] pin_in,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe,
  output led_strap_pkg::phy_addr_t phy_addr,
  output logic addr_valid
);
  import led_strap_pkg::*;

  // Synchroniser and phase state
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  pin_phase_t phase_ff;
  pin_phase_t nxt_phase;

  // Captured address
  phy_addr_t addr_ff;

  // Stretch counter
  logic [31:0] col_cnt_ff;
  logic [31:0] nxt_col_cnt;

  // Output registers and decode
  logic [4:0] out_ff;
  logic [4:0] oe_ff;
  logic valid_ff;
  logic col_led;
  logic [4:0] status;
  logic [4:0] nxt_out;

  // Two-stage synchroniser, runs through reset so it holds the straps at release
  always_ff @(posedge clock)
  begin
    sync1_ff <= pin_in;
    sync2_ff <= sync1_ff;
  end

  // Phase: one settle cycle to fill the synchroniser, one sample, then drive
  always_comb
  begin
    case (phase_ff)
      PH_RESET: nxt_phase = PH_SAMPLE;
      PH_SAMPLE: nxt_phase = PH_DRIVE;
      PH_DRIVE: nxt_phase = PH_DRIVE;
      default: nxt_phase = PH_RESET;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      phase_ff <= PH_RESET;
    else
      phase_ff <= nxt_phase;
  end

  // Strap capture after release, before the pins turn output; sw_reset not looked at
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_ff <= `PHY_ADDR_RESET;
      valid_ff <= 1'b0;
    end
    else if (phase_ff == PH_SAMPLE)
    begin
      addr_ff <= sync2_ff; // see R03 see R04 see R12 see R14 see R15 see R16
      valid_ff <= 1'b1; // see R05
    end
  end

  // Collision pulse stretcher
  assign nxt_col_cnt = collision ? COL_STRETCH : // see R07
                       (col_cnt_ff != 32'h0) ? col_cnt_ff - 32'h1 : 32'h0;
  assign col_led = collision | (col_cnt_ff != 32'h0);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      col_cnt_ff <= 32'h0;
    else
      col_cnt_ff <= nxt_col_cnt;
  end

  // Status per pin, asserted level is inverse of strap sense
  assign status[`ADDR_BIT_ACT] = tx_active | rx_active; // see R15
  assign status[`ADDR_BIT_COL] = col_led; // see R06
  assign status[`ADDR_BIT_LINK] = link_up; // see R08
  assign status[`ADDR_BIT_TX] = tx_active; // see R09
  assign status[`ADDR_BIT_RX] = rx_active; // see R10
  assign nxt_out = status ^ addr_ff; // see R13

  // Output drive, enables off through hard reset and sampling
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_ff <= 5'h00;
      oe_ff <= 5'h00; // see R01
    end
    else if (phase_ff == PH_DRIVE)
    begin
      out_ff <= nxt_out;
      oe_ff <= 5'h1F; // see R02 see R14
    end
  end

  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
  assign phy_addr = addr_ff;
  assign addr_valid = valid_ff;

  // Checks
  AST_INPUT_UNTIL_SAMPLED: assert property (@(posedge clock) disable iff (!rst_n) // see R01
    !valid_ff |-> pin_oe == 5'h00)
    else $error("pins driven before straps sampled");
  AST_DRIVE_AFTER_SAMPLE: assert property (@(posedge clock) disable iff (!rst_n) // see R02
    $rose(valid_ff) |-> ##1 pin_oe == 5'h1F)
    else $error("pins not driven after sample");
  AST_ADDR_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n) // see R12
    phase_ff == PH_SAMPLE |=> phy_addr == $past(sync2_ff))
    else $error("strap capture wrong");
  AST_ADDR_STABLE: assert property (@(posedge clock) disable iff (!rst_n) // see R16
    valid_ff |=> $stable(phy_addr))
    else $error("address changed after capture");
  AST_SW_RESET_KEEPS: assert property (@(posedge clock) disable iff (!rst_n) // see R14
    pin_oe == 5'h1F && sw_reset |=> pin_oe == 5'h1F)
    else $error("sw reset changed direction");
  AST_COL_STRETCH: assert property (@(posedge clock) disable iff (!rst_n) // see R07
    collision && valid_ff ##1 !collision [*8] |=> pin_out[1] == ~phy_addr[1])
    else $error("collision not stretched");
  AST_LINK_LEVEL: assert property (@(posedge clock) disable iff (!rst_n) // see R08
    valid_ff ##1 1'b1 |-> pin_out[2] == ($past(link_up) ^ phy_addr[2]))
    else $error("link led wrong");
  AST_TX_LEVEL: assert property (@(posedge clock) disable iff (!rst_n) // see R09
    valid_ff ##1 1'b1 |-> pin_out[3] == ($past(tx_active) ^ phy_addr[3]))
    else $error("tx led wrong");
  AST_RX_LEVEL: assert property (@(posedge clock) disable iff (!rst_n) // see R10
    valid_ff ##1 1'b1 |-> pin_out[4] == ($past(rx_active) ^ phy_addr[4]))
    else $error("rx led wrong");
  AST_ACT_LEVEL: assert property (@(posedge clock) disable iff (!rst_n) // see R15
    valid_ff ##1 1'b1 |-> pin_out[0] == (($past(tx_active) | $past(rx_active)) ^ phy_addr[0]))
    else $error("activity led wrong");

  // Further checks on the stretcher, direction, capture and activity pin
  AST_COL_LEVEL: assert property (@(posedge clock) disable iff (!rst_n) // see R06
    valid_ff ##1 1'b1 |-> pin_out[1] == ($past(col_led) ^ phy_addr[1]))
    else $error("collision led wrong");
  AST_COL_RELOAD: assert property (@(posedge clock) disable iff (!rst_n) // see R07
    collision |=> col_cnt_ff == COL_STRETCH)
    else $error("stretch not reloaded");
  AST_COL_COUNTDOWN: assert property (@(posedge clock) disable iff (!rst_n) // see R07
    !collision && col_cnt_ff != 32'h0 |=> col_cnt_ff == $past(col_cnt_ff) - 32'h1)
    else $error("stretch count not falling");
  AST_COL_IDLE: assert property (@(posedge clock) disable iff (!rst_n) // see R06
    !collision && col_cnt_ff == 32'h0 |=> col_cnt_ff == 32'h0)
    else $error("stretch started without collision");
  AST_OE_HOLDS: assert property (@(posedge clock) disable iff (!rst_n) // see R02
    pin_oe == 5'h1F |=> pin_oe == 5'h1F)
    else $error("pins left output mode");
  AST_OE_WHOLE: assert property (@(posedge clock) disable iff (!rst_n) // see R01
    pin_oe == 5'h00 || pin_oe == 5'h1F)
    else $error("pin direction split");
  AST_OUT_QUIET: assert property (@(posedge clock) disable iff (!rst_n) // see R01
    phase_ff != PH_DRIVE |-> pin_out == 5'h00)
    else $error("pin level set before drive");
  AST_SAMPLE_ONCE: assert property (@(posedge clock) disable iff (!rst_n) // see R12
    phase_ff == PH_SAMPLE |=> phase_ff == PH_DRIVE)
    else $error("sample phase repeated");
  AST_VALID_HOLDS: assert property (@(posedge clock) disable iff (!rst_n) // see R16
    addr_valid |=> addr_valid)
    else $error("address valid dropped");
  AST_DRIVE_VALID: assert property (@(posedge clock) disable iff (!rst_n) // see R16
    phase_ff == PH_DRIVE |-> addr_valid)
    else $error("driving without an address");
  AST_FIRST_EDGE: assert property (@(posedge clock) disable iff (!rst_n) // see R01
    phase_ff == PH_RESET |-> pin_oe == 5'h00 && !addr_valid)
    else $error("state not clear after reset");
  AST_SW_RESET_ADDR: assert property (@(posedge clock) disable iff (!rst_n) // see R14
    valid_ff && sw_reset |=> $stable(phy_addr))
    else $error("sw reset moved the address");
  AST_ACT_FROM_TX: assert property (@(posedge clock) disable iff (!rst_n) // see R15
    valid_ff ##1 $past(tx_active) |-> pin_out[0] == ~phy_addr[0])
    else $error("activity led dark on transmit");
  AST_ADDR_MATCHES_SYNC: assert property (@(posedge clock) disable iff (!rst_n) // see R03
    $rose(valid_ff) |-> phy_addr == $past(sync2_ff))
    else $error("address differs from strap");
endmodule

// ==== logic/led_strap_consts.svh ====
// Constants for the shared address strap and status LED pins
`ifndef LED_STRAP_CONSTS_SVH
`define LED_STRAP_CONSTS_SVH
`define CLOCK_PERIOD_PS 4000
`define COL_STRETCH_MS 70
`define COL_STRETCH_CYCLES ((`COL_STRETCH_MS * 64'd1000000000) / `CLOCK_PERIOD_PS)
`define STRAP_PIN_COUNT 5
`define ADDR_BIT_ACT 0
`define ADDR_BIT_COL 1
`define ADDR_BIT_LINK 2
`define ADDR_BIT_TX 3
`define ADDR_BIT_RX 4
`define PHY_ADDR_RESET 5'h00
`endif

// ==== logic/led_strap_pkg.sv ====
// Types for the shared address strap and status LED pins
package led_strap_pkg;
  typedef logic [4:0] phy_addr_t;
  typedef enum logic [1:0] {PH_RESET, PH_SAMPLE, PH_DRIVE} pin_phase_t;
endpackage

// ==== sim/board_pulls.sv ====
// Board pull resistors with series LEDs on the shared pins
module board_pulls (
  input wire logic [4:0] strap,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  output logic [4:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // A pin the block does not drive rests at its pull level
  assign pad = (pin_oe & pin_out) | (~pin_oe & strap);
endmodule

// ==== sim/phy_addr_strap_led_pins_test.sv ====
// Self-checking bench for the shared strap and LED pins
module phy_addr_strap_led_pins_test;
  timeunit 1ns;
  timeprecision 1ps;
  import led_strap_pkg::*;
  localparam int STR = 20;
  logic clock = 0, rst_n = 0, sw_reset = 0, collision = 0;
  logic link_up = 0, tx_active = 0, rx_active = 0, addr_valid;
  logic [4:0] strap = 5'h0A, cur = 5'h0A, pad, pin_out, pin_oe;
  phy_addr_t phy_addr;
  int err_total = 0, check_count = 0;
  always #2 clock = ~clock;
  board_pulls pull (.strap(strap), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));
  phy_addr_strap_led_pins #(.COL_STRETCH(32'(STR))) uut (.clock(clock), .rst_n(rst_n),
    .sw_reset(sw_reset), .collision(collision), .link_up(link_up), .tx_active(tx_active),
    .rx_active(rx_active), .pin_in(pad), .pin_out(pin_out), .pin_oe(pin_oe),
    .phy_addr(phy_addr), .addr_valid(addr_valid));
  // Compare one five-bit pin or address value
  task automatic cmp(string what, logic [4:0] exp, logic [4:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Pass n edges and let their updates land
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Hard reset with the given straps, then wait for the capture
  task automatic hard_reset(logic [4:0] s);
    int k;
    @(posedge clock);
    rst_n <= 0;
    strap <= s;
    cur = s;
    tick(12);
    cmp("oe in reset", 5'h00, pin_oe);
    @(posedge clock);
    rst_n <= 1;
    for (k = 0; k < 8 && addr_valid !== 1'b1; k++)
      tick(1);
    if (k == 8)
    begin
      err_total++;
      finish_test();
    end
    cmp("addr", s, phy_addr);
    tick(2);
    cmp("oe after reset", 5'h1F, pin_oe);
    $display("reset test done");
  endtask
  // Every link, transmit and receive combination, inverted by strap
  task automatic t_status();
    logic [4:0] st;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      {rx_active, tx_active, link_up} <= i[2:0];
      tick(2);
      st = {i[2], i[1], i[0], 1'b0, i[2] | i[1]};
      cmp("status pins", st ^ cur, pin_out);
    end
    $display("status test done");
  endtask
  // One-cycle collision is stretched, then released
  task automatic t_col();
    @(posedge clock);
    collision <= 1;
    @(posedge clock);
    collision <= 0;
    tick(STR - 1);
    cmp("col stretched", ~cur & 5'h02, pin_out & 5'h02);
    tick(5);
    cmp("col released", cur & 5'h02, pin_out & 5'h02);
    $display("collision test done");
  endtask
  // Soft reset with changed board levels keeps pins and address
  task automatic t_soft();
    @(posedge clock);
    sw_reset <= 1;
    strap <= ~cur;
    tick(6);
    cmp("oe soft", 5'h1F, pin_oe);
    cmp("addr soft", cur, phy_addr);
    @(posedge clock);
    sw_reset <= 0;
    $display("soft reset test done");
  endtask
  initial
  begin
    hard_reset(5'h0A);
    t_status();
    t_col();
    t_soft();
    hard_reset(5'h15);
    t_status();
    t_col();
    finish_test();
  end
endmodule
